/* File: pkg/spw_regs.svh */
// Register indices, field positions and reset values of the wake block
`ifndef SPW_REGS_SVH
`define SPW_REGS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define SPW_IDX_EN1 10'h0B0
`define SPW_IDX_EN2 10'h0B1
`define SPW_IDX_ST1 10'h0B2
`define SPW_IDX_ST2 10'h0B3
`define SPW_IDX_IRQ_ST 10'h0C0
`define SPW_IDX_IRQ_MSK 10'h0C1
`define SPW_ADDR(idx) ({(idx), 2'b00})
// ==========================================================
// Reset values and field masks
`define SPW_EN1_RST 8'h00
`define SPW_EN2_RST 8'h80
`define SPW_EN2_MASK 8'hAB
`define SPW_ST2_MASK 8'h2B
`define SPW_ZERO8 8'h00
`define SPW_OFF_BIT 7
`define SPW_GP1_BIT 4
`define SPW_GP2_BIT 5
// Latched status-one sources: ri1 ri2 keyboard_clock_pin mclk infrared_receive_two alarm
`define SPW_ST1_FALL 6'h1F
// Latched status-two sources: rxd1 rxd2 ring cir
`define SPW_ST2_FALL 4'h7
`define SPW_RESP_OK 2'h0
`define SPW_RESP_ERR 2'h2
`endif

/* File: pkg/spw_pkg.sv */
// Types shared by the wake block files
package spw_pkg;
   // ==========================================================
   // Wake pins seen by the block
   typedef struct packed {
      logic ring_indicator_one;
      logic ring_indicator_two;
      logic keyboard_clock_pin;
      logic mouse_clock_pin;
      logic infrared_receive_two;
      logic serial_rx_one;
      logic serial_rx_two;
      logic ring_input_n;
   } spw_pins_t;
   // ==========================================================
   // Internal wake signals from neighbouring blocks
   typedef struct packed {
      logic group_interrupt_one;
      logic group_interrupt_two;
      logic clock_alarm;
      logic cir_wake;
   } spw_core_t;
endpackage : spw_pkg

/* File: logic/spw_event_latch.sv */
// Sticky event latches with falling-edge or level detection
`timescale 1ns/1ps
`default_nettype none
module spw_event_latch #(
   parameter int W = 4,
   parameter logic [W-1:0] FALL = '1
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [W-1:0] src_i,
   input wire logic clear_i,
   output logic [W-1:0] held_o,
   output logic [W-1:0] set_o
);
   logic [W-1:0] prev;

   // ==========================================================
   // Previous level, idle high so reset makes no false edge
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         prev <= '1;
      end else begin
         prev <= src_i;
      end
   end

   // ==========================================================
   // Per-bit detect and hold; a new event beats the clear
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         if (FALL[g]) begin : g_fall
            assign set_o[g] = prev[g] & ~src_i[g];
         end else begin : g_level
            assign set_o[g] = src_i[g];
         end
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               held_o[g] <= 1'b0;
            end else if (set_o[g]) begin
               held_o[g] <= 1'b1;
            end else if (clear_i) begin
               held_o[g] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule : spw_event_latch
`default_nettype wire

/* File: logic/spw_wake_top.sv */
// Soft power wake enables, status and power-on request with AXI4-Lite
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "spw_regs.svh"
module spw_wake_top
   import spw_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Wake sources
   input wire spw_pins_t pins_i,
   input wire spw_core_t core_i,
   // Power control
   output logic power_on_request_n,
   output logic button_off_enable_o,
   output logic irq_o
);
   logic [7:0] wake_enable_one;
   logic [7:0] wake_enable_two;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic [1:0] group_level;
   logic [5:0] st1_held;
   logic [5:0] st1_set;
   logic [3:0] st2_held;
   logic [3:0] st2_set;
   logic [7:0] wake_status_one;
   logic [7:0] wake_status_two;
   logic [7:0] st1_prev;
   logic aw_held;
   logic w_held;
   logic [9:0] aw_idx;
   logic [7:0] w_byte;
   logic w_lane0;
   logic do_write;
   logic ar_take;
   logic clr_st1;
   logic clr_st2;
   logic next_power_n;

   // ==========================================================
   // Address decode shared by read and write paths
   function automatic logic idx_known(input logic [9:0] idx);
      idx_known = (idx == `SPW_IDX_EN1) || (idx == `SPW_IDX_EN2) ||
                  (idx == `SPW_IDX_ST1) || (idx == `SPW_IDX_ST2) ||
                  (idx == `SPW_IDX_IRQ_ST) || (idx == `SPW_IDX_IRQ_MSK);
   endfunction : idx_known

   // ==========================================================
   // Write channel capture, either order
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         aw_held <= 1'b0;
         aw_idx <= 10'h000;
         s_axi_awready <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[11:2];
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid
                          && s_axi_awvalid;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         w_held <= 1'b0;
         w_byte <= `SPW_ZERO8;
         w_lane0 <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held <= 1'b0;
         end
         s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid
                         && s_axi_wvalid;
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SPW_RESP_OK;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= idx_known(aw_idx) ? `SPW_RESP_OK : `SPW_RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Enable registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wake_enable_one <= `SPW_EN1_RST;
         wake_enable_two <= `SPW_EN2_RST;
      end else if (do_write && w_lane0) begin
         if (aw_idx == `SPW_IDX_EN1) begin
            wake_enable_one <= w_byte;
         end
         if (aw_idx == `SPW_IDX_EN2) begin
            wake_enable_two <= w_byte & `SPW_EN2_MASK;
         end
      end
   end

   // Button-off enable handed to the power-off timer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         button_off_enable_o <= 1'b1;
      end else begin
         button_off_enable_o <= wake_enable_two[`SPW_OFF_BIT];
      end
   end

   // ==========================================================
   // Read channel; a read of wake status one or two clears its latched bits
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign clr_st1 = ar_take && (s_axi_araddr[11:2] == `SPW_IDX_ST1);
   assign clr_st2 = ar_take && (s_axi_araddr[11:2] == `SPW_IDX_ST2);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SPW_RESP_OK;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= idx_known(s_axi_araddr[11:2]) ? `SPW_RESP_OK
                                                      : `SPW_RESP_ERR;
         case (s_axi_araddr[11:2])
            `SPW_IDX_EN1: s_axi_rdata <= {24'h000000, wake_enable_one};
            `SPW_IDX_EN2: s_axi_rdata <= {24'h000000, wake_enable_two};
            `SPW_IDX_ST1: s_axi_rdata <= {24'h000000, wake_status_one};
            `SPW_IDX_ST2: s_axi_rdata <= {24'h000000, wake_status_two};
            `SPW_IDX_IRQ_ST: s_axi_rdata <= {24'h000000, irq_status};
            `SPW_IDX_IRQ_MSK: s_axi_rdata <= {24'h000000, irq_mask};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // Status one: ri1 ri2 keyboard_clock_pin mclk infrared_receive_two fall, alarm level
   spw_event_latch #(
      .W(6),
      .FALL(`SPW_ST1_FALL)
   ) u_st1 (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .src_i({core_i.clock_alarm, pins_i.infrared_receive_two,
              pins_i.mouse_clock_pin, pins_i.keyboard_clock_pin,
              pins_i.ring_indicator_two, pins_i.ring_indicator_one}),
      .clear_i(clr_st1),
      .held_o(st1_held),
      .set_o(st1_set)
   );

   // Group interrupts follow the source, no latch
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         group_level <= 2'h0;
      end else begin
         group_level <= {core_i.group_interrupt_two,
                         core_i.group_interrupt_one};
      end
   end

   // Status layout: bits 0-3 pins, 4-5 groups, 6 infrared_receive_two, 7 alarm
   assign wake_status_one = {st1_held[5:4], group_level,
                             st1_held[3:0]};

   // Status two: rxd1 rxd2 ring fall, cir level
   spw_event_latch #(
      .W(4),
      .FALL(`SPW_ST2_FALL)
   ) u_st2 (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .src_i({core_i.cir_wake, pins_i.ring_input_n,
              pins_i.serial_rx_two, pins_i.serial_rx_one}),
      .clear_i(clr_st2),
      .held_o(st2_held),
      .set_o(st2_set)
   );
   assign wake_status_two = {2'h0, st2_held[3], 1'b0, st2_held[2], 1'b0,
                             st2_held[1:0]};

   // ==========================================================
   // Power-on request, low while an enabled event is present
   assign next_power_n = ~(|(wake_status_one & wake_enable_one) |
                           |(wake_status_two & wake_enable_two
                             & `SPW_ST2_MASK));

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         power_on_request_n <= 1'b1;
      end else begin
         power_on_request_n <= next_power_n;
      end
   end

   // ==========================================================
   // Interrupt: rising status-one bits set sticky, write one clears
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st1_prev <= `SPW_ZERO8;
      end else begin
         st1_prev <= wake_status_one;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_status <= `SPW_ZERO8;
         irq_mask <= `SPW_ZERO8;
      end else begin
         if (do_write && w_lane0 && aw_idx == `SPW_IDX_IRQ_MSK) begin
            irq_mask <= w_byte;
         end
         if (do_write && w_lane0 && aw_idx == `SPW_IDX_IRQ_ST) begin
            irq_status <= (irq_status & ~w_byte)
                          | (wake_status_one & ~st1_prev);
         end else begin
            irq_status <= irq_status | (wake_status_one & ~st1_prev);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   sequence s_ring_fall;
      pins_i.ring_indicator_one ##1 !pins_i.ring_indicator_one;
   endsequence

   sequence s_status_read;
      s_axi_arvalid && s_axi_arready
         && s_axi_araddr[11:2] == `SPW_IDX_ST1;
   endsequence

   chk_ring_latch: assert property (
      s_ring_fall |=> wake_status_one[0])
      else $error("ring indicator fall not latched");

   chk_keyboard_clock_pin_latch: assert property (
      $fell(pins_i.keyboard_clock_pin) |=> wake_status_one[2])
      else $error("keyboard clock fall not latched");

   chk_irrx_latch: assert property (
      $fell(pins_i.infrared_receive_two) |=> wake_status_one[6])
      else $error("infrared fall not latched");

   chk_read_clears: assert property (
      s_status_read and ##0 (pins_i.ring_indicator_one
         || $past(pins_i.ring_indicator_one) == 1'b0)
      |=> !wake_status_one[0])
      else $error("status read did not clear ring bit");

   chk_alarm_clear: assert property (
      s_status_read ##0 !core_i.clock_alarm |=> !wake_status_one[7])
      else $error("alarm bit not cleared by read");

   chk_group_follow: assert property (
      ##1 wake_status_one[`SPW_GP1_BIT] == $past(core_i.group_interrupt_one)
      && wake_status_one[`SPW_GP2_BIT] == $past(core_i.group_interrupt_two))
      else $error("group bits do not follow source");

   chk_power_req: assert property (
      |(wake_status_one & wake_enable_one) |=> !power_on_request_n)
      else $error("enabled event did not request power");

   chk_ring_block: assert property (
      (wake_status_one & wake_enable_one) == `SPW_ZERO8
      && (wake_status_two & wake_enable_two & `SPW_ST2_MASK) == `SPW_ZERO8
      |=> power_on_request_n)
      else $error("power requested with no enabled event");

   chk_reserved_zero: assert property (
      (wake_enable_two & ~`SPW_EN2_MASK) == `SPW_ZERO8)
      else $error("reserved enable bits set");

   chk_off_enable: assert property (
      ##1 button_off_enable_o == $past(wake_enable_two[`SPW_OFF_BIT]))
      else $error("button-off enable mismatch");
endmodule : spw_wake_top
`default_nettype wire

/* File: tb/spw_src_model.sv */
// Wake source pins and internal wake signals seen by the block
`timescale 1ns/1ps
`default_nettype none
module spw_src_model
   import spw_pkg::*;
(
   input wire logic clk_i,
   output var spw_pins_t pins_o,
   output var spw_core_t core_o
);
   // =====
   // Idle pins rest high, internal levels low
   initial begin
      pins_o = '1;
      core_o = '0;
   end
   // Pin pulled low three cycles, then back high
   task pin_fall(input int i);
      pins_o[i] <= 1'b0;
      repeat (3) @(posedge clk_i);
      pins_o[i] <= 1'b1;
      @(posedge clk_i);
   endtask : pin_fall
   // Internal level raised or dropped, then held
   task core_set(input int i, input logic v);
      core_o[i] <= v;
      repeat (3) @(posedge clk_i);
   endtask : core_set
endmodule : spw_src_model
`default_nettype wire

/* File: tb/spw_wake_top_tb.sv */
// Self-checking bench of the wake block over its register bus
`timescale 1ns/1ps
`default_nettype none
module spw_wake_top_tb
   import spw_pkg::*;
;
   // =====
   // Addresses, bus signals and bookkeeping
   localparam logic [11:0] A_EN1 = 12'h2C0;
   localparam logic [11:0] A_EN2 = 12'h2C4;
   localparam logic [11:0] A_ST1 = 12'h2C8;
   localparam logic [11:0] A_ST2 = 12'h2CC;
   localparam logic [11:0] A_IST = 12'h300;
   localparam logic [11:0] A_IMK = 12'h304;
   logic clk_i = 1'b0;
   logic srst_i;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, req_n, boff, irq;
   logic [1:0] bresp, rresp, rs;
   spw_pins_t pins;
   spw_core_t core;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int pl[5] = '{7, 6, 5, 4, 3};
   int bl[5] = '{0, 1, 2, 3, 6};
   int pb[4] = '{2, 1, 0, 0};
   int eb[4] = '{0, 1, 3, 5};

   spw_wake_top i_spw_wake_top (
      .clk_i(clk_i), .srst_i(srst_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pins_i(pins), .core_i(core), .power_on_request_n(req_n),
      .button_off_enable_o(boff), .irq_o(irq)
   );
   spw_src_model i_spw_src_model (
      .clk_i(clk_i), .pins_o(pins), .core_o(core)
   );

   // Clock of 20 ns
   always #10 clk_i = ~clk_i;
   // Cycle ceiling against a hung handshake
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         $display("wrong value at %0t: timeout", $time);
         summarize();
      end
   end

   // =====
   // Shared tasks
   task summarize();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: %s got %0h", $time, m, g);
      end
   endtask : chk
   // Write: address and data offered together, each dropped when taken
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk_i);
         if (!aw && awready === 1'b1) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_i); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task rdr(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_i); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge clk_i);
   endtask : rdr
   task req(input logic v);
      repeat (4) @(posedge clk_i);
      chk(32'(req_n), 32'(v), "power on request");
   endtask : req
   task ev2(input int k);
      if (k == 3) begin
         i_spw_src_model.core_set(0, 1'b1);
         i_spw_src_model.core_set(0, 1'b0);
      end else begin
         i_spw_src_model.pin_fall(pb[k]);
      end
   endtask : ev2

   // =====
   // Scenarios
   task t_reset();
      chk(32'(boff), 32'h1, "button off");
      chk(32'(req_n), 32'h1, "request idle");
      rdr(A_EN2);
      chk(rd, 32'h80, "enable two");
      rdr(A_EN1);
      chk(rd, 32'h0, "enable one");
      rdr(A_ST1);
      chk(rd, 32'h0, "status one");
      $display("test reset done");
   endtask : t_reset
   task t_en2();
      wr(A_EN2, 32'hFF);
      chk(32'(rs), 32'h0, "write response");
      rdr(A_EN2);
      chk(rd, 32'hAB, "reserved bits");
      wr(A_EN2, 32'h00);
      chk(32'(boff), 32'h0, "button off");
      wr(A_EN2, 32'h80);
      rdr(12'h010);
      chk(32'(rs), 32'h2, "unmapped");
      chk(rd, 32'h0, "unmapped data");
      wr(12'h010, 32'hFF);
      chk(32'(rs), 32'h2, "unmapped write");
      // Lane zero off: write answered but ignored
      wstrb <= 4'hE;
      wr(A_EN2, 32'h00);
      wstrb <= 4'hF;
      rdr(A_EN2);
      chk(rd, 32'h80, "lane zero off");
      $display("test enable two done");
   endtask : t_en2
   task t_latch();
      for (int k = 0; k < 5; k++) begin
         i_spw_src_model.pin_fall(pl[k]);
         req(1'b1);
         rdr(A_ST1);
         chk(rd, 32'h1 << bl[k], "edge latch");
         rdr(A_ST1);
         chk(rd, 32'h0, "read clear");
      end
      $display("test latch done");
   endtask : t_latch
   task t_level();
      for (int k = 0; k < 2; k++) begin
         i_spw_src_model.core_set(3 - k, 1'b1);
         rdr(A_ST1);
         rdr(A_ST1);
         chk(rd, 32'h10 << k, "group level");
         i_spw_src_model.core_set(3 - k, 1'b0);
         rdr(A_ST1);
         chk(rd, 32'h0, "group drop");
      end
      i_spw_src_model.core_set(1, 1'b1);
      i_spw_src_model.core_set(1, 1'b0);
      rdr(A_ST1);
      chk(rd, 32'h80, "alarm seen");
      rdr(A_ST1);
      chk(rd, 32'h0, "alarm clear");
      $display("test level done");
   endtask : t_level
   task t_wake1();
      for (int k = 0; k < 2; k++) begin
         wr(A_EN1, k ? 32'h40 : 32'h01);
         i_spw_src_model.pin_fall(k ? 3 : 7);
         req(1'b0);
         rdr(A_ST1);
         req(1'b1);
      end
      wr(A_EN1, 32'h10);
      i_spw_src_model.core_set(3, 1'b1);
      req(1'b0);
      i_spw_src_model.core_set(3, 1'b0);
      req(1'b1);
      wr(A_EN1, 32'h0);
      $display("test wake one done");
   endtask : t_wake1
   task t_wake2();
      ev2(0);
      req(1'b1);
      rdr(A_ST2);
      for (int k = 0; k < 4; k++) begin
         wr(A_EN2, 32'h80 | (32'h1 << eb[k]));
         ev2(k);
         req(1'b0);
         rdr(A_ST2);
         chk(rd, 32'h1 << eb[k], "status two");
         req(1'b1);
      end
      wr(A_EN2, 32'h80);
      $display("test wake two done");
   endtask : t_wake2
   task t_irq();
      logic a;
      wr(A_IST, 32'hFF);
      wr(A_IMK, 32'h00);
      i_spw_src_model.pin_fall(5);
      repeat (3) @(posedge clk_i);
      a = irq;
      wr(A_IMK, 32'hFF);
      repeat (3) @(posedge clk_i);
      chk(32'(a), 32'h0, "irq masked");
      chk(32'(irq), 32'h1, "irq unmasked");
      rdr(A_IST);
      chk(rd, 32'h04, "irq status");
      wr(A_IST, 32'h04);
      wr(A_IMK, 32'h00);
      rdr(A_IST);
      chk(rd, 32'h0, "irq clear");
      chk(32'(irq), 32'h0, "irq low");
      rdr(A_ST1);
      $display("test irq done");
   endtask : t_irq

   // Reset for five cycles, then the scenarios
   initial begin
      srst_i = 1'b1;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_en2();
      t_latch();
      t_level();
      t_wake1();
      t_wake2();
      t_irq();
      summarize();
   end
endmodule : spw_wake_top_tb
`default_nettype wire
